// file: src/nsac_top.v
//
// Behaviour
// - memories reached only through seven registers: address pair, data pair, control, unlock, status
// - data access uses low data byte and low address byte
// - data memory 128 or 256 bytes; upper half wraps on small parts
// - write to unimplemented data location switches charge pump off
// - program access uses 14-bit data word and 13-bit address word
// - program memory 4K or 8K words; higher addresses wrap to start
// - data single byte read and write; program single word read, four-word writes
// - program write erases containing four-word block first, then programs
// - data byte write erases the byte first, then programs
// - every erase and write timed by internal timer
// - code protection still allows processor data memory access
// - code protection blocks protected program writes, reads always allowed
// - code protection refuses external programmer, processor unaffected
// - address bits above implemented size do not exist
// - space select clear means data memory, set means program memory; resets clear
// - read and write triggers set-only by software, cleared by hardware
// - writes need permit bit, clear at reset; abort flag on interrupted write
// - write done flag set on completion, held until software clears
`timescale 1ns/1ps
`include "nsac_defs.vh"

module nsac_top #(
	parameter DATA_BYTES    = 256,
	parameter PROG_WORDS    = 8192,
	parameter WRITE_CYCLES  = `NSAC_WRITE_CYCLES,
	parameter ERASE_CYCLES  = `NSAC_ERASE_CYCLES
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        reset_n,
	// register port
	input  wire [2:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// protection and reset causes
	input  wire        code_protect,
	input  wire [1:0]  write_protect,
	input  wire        abort_reset,
	input  wire        ext_prog_req,
	// status outputs
	output wire        ext_prog_grant,
	output wire        charge_pump_on,
	output wire        write_done_irq
);

	localparam DA_W = (DATA_BYTES > 128) ? 8 : 7;
	localparam PA_W = (PROG_WORDS > 4096) ? 13 : 12;

	localparam ST_IDLE  = 2'd0;
	localparam ST_ERASE = 2'd1;
	localparam ST_PROG  = 2'd2;

	// memory arrays
	reg  [7:0]  data_mem [0:DATA_BYTES-1];
	reg  [13:0] prog_mem [0:PROG_WORDS-1];
	reg  [13:0] latch_ff [0:3];

	reg  [7:0]  data_low_ff;
	reg  [5:0]  data_high_ff;
	reg  [7:0]  addr_low_ff;
	reg  [4:0]  addr_high_ff;
	reg         space_ff;
	reg         permit_ff;
	reg         abort_ff;
	reg         rd_trig_ff;
	reg         wr_trig_ff;
	reg         done_ff;
	reg         irq_en_ff;
	reg  [1:0]  key_ff;
	reg  [1:0]  state_ff;
	reg  [15:0] timer_ff;
	reg         pump_ff;
	reg  [1:0]  lat_cnt_ff;
	integer     i;

	////////////////////////////////////////////////////////////////
	// address decode and derived values
	// unimplemented low address bit reads back as zero on small data parts
	localparam [7:0] DA_MASK = (DA_W == 8) ? 8'hFF : 8'h7F;

	wire [DA_W-1:0] d_addr = addr_low_ff[DA_W-1:0];
	wire [12:0]     p_full = {addr_high_ff, addr_low_ff};
	wire [PA_W-1:0] p_addr = p_full[PA_W-1:0];
	wire            d_unimpl = (DATA_BYTES == 128) && addr_low_ff[7];
	wire            busy = (state_ff != ST_IDLE) || rd_trig_ff;
	wire [1:0]      blk_sel = p_addr[PA_W-1 -: 2];
	wire            blk_prot = code_protect && (write_protect != 2'b00) &&
	                           (blk_sel >= (2'd3 - write_protect + 2'd1));
	wire            wr_ctl = reg_wr && (reg_addr == `NSAC_ADR_CONTROL);
	wire            start_rd = wr_ctl && reg_wdata[`NSAC_CTL_READ] && !busy;
	wire            start_wr = wr_ctl && reg_wdata[`NSAC_CTL_WRITE] && !busy &&
	                           permit_ff && (key_ff == 2'd2);

	assign ext_prog_grant = ext_prog_req && !code_protect;
	assign charge_pump_on = pump_ff;
	assign write_done_irq = done_ff && irq_en_ff;

	////////////////////////////////////////////////////////////////
	// software-visible registers
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_low_ff  <= `NSAC_BYTE_RESET;
			data_high_ff <= 6'h00;
			addr_low_ff  <= `NSAC_BYTE_RESET;
			addr_high_ff <= 5'h00;
			space_ff     <= 1'b0;
			permit_ff    <= 1'b0;
			irq_en_ff    <= 1'b0;
			key_ff       <= 2'd0;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
				`NSAC_ADR_DATA_LOW:  data_low_ff  <= reg_wdata;
				`NSAC_ADR_DATA_HIGH: data_high_ff <= reg_wdata[5:0];
				`NSAC_ADR_ADDR_LOW:  addr_low_ff  <= reg_wdata;
				`NSAC_ADR_ADDR_HIGH: addr_high_ff <= reg_wdata[4:0];
				`NSAC_ADR_CONTROL: begin
					space_ff  <= reg_wdata[`NSAC_CTL_SPACE];
					permit_ff <= reg_wdata[`NSAC_CTL_PERMIT];
				end
				`NSAC_ADR_STATUS:    irq_en_ff    <= reg_wdata[`NSAC_STS_IRQ_EN];
				default: ;
				endcase
			end
			// unlock key sequence, consumed by a write trigger
			if (reg_wr && reg_addr == `NSAC_ADR_UNLOCK) begin
				if (reg_wdata == `NSAC_KEY_FIRST)
					key_ff <= 2'd1;
				else if (reg_wdata == `NSAC_KEY_SECOND && key_ff == 2'd1)
					key_ff <= 2'd2;
				else
					key_ff <= 2'd0;
			end else if (reg_wr) begin
				key_ff <= (wr_ctl && key_ff == 2'd2 && !start_wr) ? key_ff : 2'd0;
			end
			// read result lands in data registers
			if (rd_trig_ff) begin
				if (space_ff) begin
					data_low_ff  <= prog_mem[p_addr][7:0];
					data_high_ff <= prog_mem[p_addr][13:8];
				end else
					data_low_ff  <= data_mem[d_addr];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// trigger bits, abort and done flags
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_trig_ff <= 1'b0;
			wr_trig_ff <= 1'b0;
			done_ff    <= 1'b0;
		end else begin
			// read completes in one cycle
			rd_trig_ff <= start_rd;
			if (start_wr)
				wr_trig_ff <= 1'b1;
			else if (state_ff == ST_PROG && timer_ff == 16'd0)
				wr_trig_ff <= 1'b0;
			// set wins over software clear
			if (state_ff == ST_PROG && timer_ff == 16'd0)
				done_ff <= 1'b1;
			else if (reg_wr && reg_addr == `NSAC_ADR_STATUS &&
			         !reg_wdata[`NSAC_STS_DONE])
				done_ff <= 1'b0;
		end
	end

	// abort flag survives the interrupting reset
	always @(posedge ref_clk) begin
		if (abort_reset && wr_trig_ff)
			abort_ff <= 1'b1;
		else if (wr_ctl && !reg_wdata[`NSAC_CTL_ABORT])
			abort_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// program latches: each write on non-final word only latches
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			lat_cnt_ff <= 2'd0;
		else if (start_wr && space_ff)
			lat_cnt_ff <= lat_cnt_ff + 2'd1;
	end

	always @(posedge ref_clk) begin
		if (start_wr && space_ff)
			latch_ff[p_addr[1:0]] <= {data_high_ff, data_low_ff};
	end

	////////////////////////////////////////////////////////////////
	// erase-then-program sequencer with internal timer
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			timer_ff <= 16'd0;
			pump_ff  <= 1'b0;
		end else begin
			case (state_ff)
			ST_IDLE: begin
				if (start_wr) begin
					state_ff <= ST_ERASE;
					timer_ff <= ERASE_CYCLES[15:0] - 16'd1;
					pump_ff  <= !(space_ff ? blk_prot : d_unimpl);
				end
			end
			ST_ERASE: begin
				if (timer_ff == 16'd0) begin
					state_ff <= ST_PROG;
					timer_ff <= WRITE_CYCLES[15:0] - 16'd1;
				end else
					timer_ff <= timer_ff - 16'd1;
			end
			ST_PROG: begin
				if (timer_ff == 16'd0) begin
					state_ff <= ST_IDLE;
					pump_ff  <= 1'b0;
				end else
					timer_ff <= timer_ff - 16'd1;
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// array erase at the end of the erase phase, update at the end of the program phase
	always @(posedge ref_clk) begin
		if (state_ff == ST_ERASE && timer_ff == 16'd0 && pump_ff) begin
			if (!space_ff)
				data_mem[d_addr] <= 8'hFF;
			else if (lat_cnt_ff == 2'd0)
				for (i = 0; i < 4; i = i + 1)
					prog_mem[{p_addr[PA_W-1:2], i[1:0]}] <= 14'h3FFF;
		end
		if (state_ff == ST_PROG && timer_ff == 16'd0 && pump_ff) begin
			if (!space_ff)
				data_mem[d_addr] <= data_low_ff;
			else if (lat_cnt_ff == 2'd0)
				for (i = 0; i < 4; i = i + 1)
					prog_mem[{p_addr[PA_W-1:2], i[1:0]}] <= latch_ff[i];
		end
	end

	////////////////////////////////////////////////////////////////
	// read port, answer one cycle after the strobe; unlock reads zero
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
			`NSAC_ADR_DATA_LOW:  reg_rdata <= data_low_ff;
			`NSAC_ADR_DATA_HIGH: reg_rdata <= {2'b00, data_high_ff};
			`NSAC_ADR_ADDR_LOW:  reg_rdata <= space_ff ? addr_low_ff :
			                     (addr_low_ff & DA_MASK);
			`NSAC_ADR_ADDR_HIGH: reg_rdata <= {{(16-PA_W){1'b0}}, p_addr[PA_W-1:8]};
			`NSAC_ADR_CONTROL:   reg_rdata <= {space_ff, 3'b000, abort_ff,
			                                   permit_ff, wr_trig_ff, rd_trig_ff};
			`NSAC_ADR_STATUS:    reg_rdata <= {4'h0, pump_ff, busy, irq_en_ff, done_ff};
			default:             reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

endmodule // nsac_top

// file: common/nsac_defs.vh
`ifndef NSAC_DEFS_VH
`define NSAC_DEFS_VH

// register indices on the plain port
`define NSAC_ADR_DATA_LOW   3'h0
`define NSAC_ADR_DATA_HIGH  3'h1
`define NSAC_ADR_ADDR_LOW   3'h2
`define NSAC_ADR_ADDR_HIGH  3'h3
`define NSAC_ADR_CONTROL    3'h4
`define NSAC_ADR_UNLOCK     3'h5
`define NSAC_ADR_STATUS     3'h6

// control register fields
`define NSAC_CTL_READ       0
`define NSAC_CTL_WRITE      1
`define NSAC_CTL_PERMIT     2
`define NSAC_CTL_ABORT      3
`define NSAC_CTL_SPACE      7

// status register fields
`define NSAC_STS_DONE       0
`define NSAC_STS_IRQ_EN     1
`define NSAC_STS_BUSY       2
`define NSAC_STS_PUMP       3

// reset values
`define NSAC_CTL_RESET      8'h00
`define NSAC_BYTE_RESET     8'h00

// unlock key pair
`define NSAC_KEY_FIRST      8'h55
`define NSAC_KEY_SECOND     8'hAA

// write timing: program time in microseconds, cycles at 125 MHz
`define NSAC_WRITE_TIME_US  4
`define NSAC_CLK_MHZ        125
`define NSAC_WRITE_CYCLES   (`NSAC_WRITE_TIME_US * `NSAC_CLK_MHZ)
`define NSAC_ERASE_CYCLES   (`NSAC_WRITE_TIME_US * `NSAC_CLK_MHZ)

`endif

// file: sim/nsac_chk.sv
`timescale 1ns/1ps
`include "nsac_defs.vh"
module nsac_chk #(
	parameter WRITE_CYCLES = 4,
	parameter ERASE_CYCLES = 4
) (
	// clock and reset
	input wire       ref_clk,
	input wire       reset_n,
	// register port
	input wire [2:0] reg_addr,
	input wire       reg_rd,
	input wire       reg_wr,
	input wire [7:0] reg_rdata,
	// protection and status
	input wire       code_protect,
	input wire       ext_prog_req,
	input wire       ext_prog_grant,
	input wire       charge_pump_on,
	input wire       write_done_irq
);
////////////////////////////////////////////////////////////////
// length of the current pump burst
reg  [15:0] pump_cnt_ff;
wire [15:0] nxt_pump_cnt = charge_pump_on ? pump_cnt_ff + 16'h0001 : 16'h0000;
always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) pump_cnt_ff <= 16'h0000;
	else pump_cnt_ff <= nxt_pump_cnt;
end
////////////////////////////////////////////////////////////////
// read strobes of interest
default clocking @(posedge ref_clk); endclocking
default disable iff (!reset_n);
sequence s_rd_unlock; reg_rd && reg_addr == `NSAC_ADR_UNLOCK; endsequence
sequence s_rd_status; reg_rd && reg_addr == `NSAC_ADR_STATUS; endsequence
sequence s_rd_ctl_busy; reg_rd && reg_addr == `NSAC_ADR_CONTROL && charge_pump_on; endsequence
////////////////////////////////////////////////////////////////
a_grant_gate: assert property (
	ext_prog_grant == (ext_prog_req && !code_protect)) else $error("grant ignores protection");
a_rdata_quiet: assert property (
	!reg_rd |=> reg_rdata == 8'h00) else $error("read data without strobe");
a_unlock_zero: assert property (
	s_rd_unlock |=> reg_rdata == 8'h00) else $error("unlock register not zero");
a_status_pump: assert property (
	s_rd_status |=> reg_rdata[`NSAC_STS_PUMP] == $past(charge_pump_on))
	else $error("pump bit wrong");
a_busy_shown: assert property (
	s_rd_status ##0 charge_pump_on |=> reg_rdata[`NSAC_STS_BUSY]) else $error("busy not shown");
a_trigger_held: assert property (
	s_rd_ctl_busy |=> reg_rdata[`NSAC_CTL_WRITE]) else $error("write trigger dropped early");
a_done_sticky: assert property (
	write_done_irq && !reg_wr |=> write_done_irq) else $error("done flag cleared by itself");
a_pump_bounded: assert property (
	pump_cnt_ff <= ERASE_CYCLES + WRITE_CYCLES) else $error("pump on too long");
endmodule // nsac_chk
bind nsac_top nsac_chk #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_rdata(reg_rdata), .code_protect(code_protect),
	.ext_prog_req(ext_prog_req), .ext_prog_grant(ext_prog_grant),
	.charge_pump_on(charge_pump_on), .write_done_irq(write_done_irq));

// file: sim/tb_nsac_top.sv
`timescale 1ns/1ps
`include "nsac_defs.vh"
module tb_nsac_top;
reg        ref_clk, reset_n, reg_wr, reg_rd, code_protect, abort_reset, ext_prog_req;
reg  [2:0] reg_addr;
reg  [7:0] reg_wdata, rv;
reg  [1:0] write_protect;
wire [7:0] reg_rdata;
wire       ext_prog_grant, charge_pump_on, write_done_irq;
integer    fails, compares;
// small parts, short write timing
nsac_top #(.DATA_BYTES(128), .PROG_WORDS(4096), .WRITE_CYCLES(4), .ERASE_CYCLES(4)) dut (
	.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_protect(code_protect),
	.write_protect(write_protect), .abort_reset(abort_reset), .ext_prog_req(ext_prog_req),
	.ext_prog_grant(ext_prog_grant), .charge_pump_on(charge_pump_on),
	.write_done_irq(write_done_irq));
////////////////////////////////////////////////////////////////
// bus and compare tasks
task chk(input [7:0] got, input [7:0] exp);
	compares = compares + 1;
	if (got !== exp) begin
		fails = fails + 1;
		$display("mismatch at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task wr(input [2:0] a, input [7:0] d);
	@(posedge ref_clk);
	reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
	@(posedge ref_clk);
	reg_wr <= 1'b0;
endtask
task rd(input [2:0] a);
	@(posedge ref_clk);
	reg_addr <= a; reg_rd <= 1'b1;
	@(posedge ref_clk);
	reg_rd <= 1'b0;
	#1 rv = reg_rdata;
endtask
// permit, unlock pair, then trigger
task go(input [7:0] sp);
	wr(4, sp | 8'h04); wr(5, 8'h55); wr(5, 8'hAA); wr(4, sp | 8'h06);
endtask
task idle;
	integer n;
	n = 0;
	rd(6);
	while (rv[2] !== 1'b0 && n < 50) begin
		rd(6); n = n + 1;
	end
	chk(rv & 8'h04, 8'h00);
endtask
task pblock(input [7:0] ah, input [7:0] al, input [7:0] hi);
	integer i;
	for (i = 0; i < 4; i = i + 1) begin
		wr(3, ah); wr(2, al + i); wr(1, hi); wr(0, 8'h40 + i); go(8'h80); idle;
	end
endtask
task pcheck(input [7:0] ah, input [7:0] al, input [7:0] hi);
	integer i;
	for (i = 0; i < 4; i = i + 1) begin
		wr(3, ah); wr(2, al + i); wr(4, 8'h81);
		rd(1); chk(rv, hi);
		rd(0); chk(rv, 8'h40 + i);
	end
endtask
////////////////////////////////////////////////////////////////
// scenarios
task t_reset;
	rd(4); chk(rv & 8'hF7, 8'h00);
	rd(6); chk(rv, 8'h00);
	wr(4, 8'h00);
	$display("test reset done");
endtask
task t_data;
	integer k;
	wr(6, 8'h02); wr(2, 8'h12);
	for (k = 0; k < 2; k = k + 1) begin
		wr(0, k ? 8'hA5 : 8'h5A); go(8'h00);
		rd(4); chk(rv & 8'h02, 8'h02);
		idle;
		chk({7'h00, write_done_irq}, 8'h01);
		wr(6, 8'h02); #1 chk({7'h00, write_done_irq}, 8'h00);
		wr(0, 8'h00); wr(4, 8'h01);
		rd(0); chk(rv, k ? 8'hA5 : 8'h5A);
	end
	$display("test data done");
endtask
task t_refuse;
	wr(0, 8'h33); wr(4, 8'h02); wr(4, 8'h01);
	rd(0); chk(rv, 8'hA5);
	wr(2, 8'h92); wr(4, 8'h01);
	rd(0); chk(rv, 8'hA5);
	wr(0, 8'h77); go(8'h00);
	rd(6); chk(rv & 8'h08, 8'h00);
	idle; wr(2, 8'h12); go(8'h00);
	@(posedge ref_clk) abort_reset <= 1'b1;
	@(posedge ref_clk) abort_reset <= 1'b0;
	idle; rd(4); chk(rv & 8'h08, 8'h08);
	wr(4, 8'h00);
	$display("test refuse done");
endtask
task t_prog;
	@(posedge ref_clk) ext_prog_req <= 1'b1;
	@(posedge ref_clk) #1 chk({7'h00, ext_prog_grant}, 8'h01);
	pblock(8'h0C, 8'h10, 8'h21);
	pcheck(8'h1C, 8'h10, 8'h21);
	code_protect <= 1'b1; write_protect <= 2'b01; ext_prog_req <= 1'b1;
	@(posedge ref_clk) #1 chk({7'h00, ext_prog_grant}, 8'h00);
	pblock(8'h0C, 8'h10, 8'h12);
	pcheck(8'h0C, 8'h10, 8'h21);
	wr(3, 8'h00); wr(2, 8'h12); wr(0, 8'h6C); go(8'h00); idle; wr(4, 8'h01);
	rd(0); chk(rv, 8'h6C);
	$display("test program done");
endtask
task complete_run;
	$display("compares %0d fails %0d", compares, fails);
	if (fails == 0 && compares > 0) $display("verification passed");
	else $display("verification failed");
	$finish;
endtask
////////////////////////////////////////////////////////////////
// clock
initial begin
	ref_clk = 1'b0;
	forever #4 ref_clk = ~ref_clk;
end
// watchdog
initial begin
	#300000;
	fails = fails + 1;
	$display("mismatch at %0t: watchdog expired", $time);
	complete_run;
end
// main sequence
initial begin
	{reset_n, reg_wr, reg_rd, code_protect, abort_reset, ext_prog_req} = 6'h00;
	reg_addr = 3'h0; reg_wdata = 8'h00; write_protect = 2'h0; fails = 0; compares = 0;
	repeat (4) @(posedge ref_clk);
	reset_n <= 1'b1;
	t_reset; t_data; t_refuse; t_prog;
	complete_run;
end
endmodule // tb_nsac_top
